// file: shared/prot_pkg.sv
// Constants and types shared by the sector protection logic
// How it works
// - Permitted write, bits 5:2 all one: protect all
// - Permitted write, bits 5:2 all zero: unprotect all
// - Mixed bits 5:2 leave sector bits unchanged
// - Pin low and lock set: write ignored
// - Pin high, lock set: only lock loads
// - Unlocked write stores bit 7 as lock
// - Bits 5:2 decoded, readback shows pin, summary
// - 00h unprotects, 7Fh protects, FFh protects and locks
// - 0Fh clears lock, F0h sets lock only
// - Then repeat FFh if protected, else 00h
// - Chip select high ends reply, output released
// - Reply shows sector bit only, not pin
// - Summary of all, some or no protection
// - Status write needs write enable latch set
// - Reset leaves every sector protected
// - Hard lock needs pin low and lock set
package prot_pkg;

   localparam logic [7:0] CMD_WREN   = 8'h06;
   localparam logic [7:0] CMD_WRDI   = 8'h04;
   localparam logic [7:0] CMD_WRSR   = 8'h01;
   localparam logic [7:0] CMD_RDSR   = 8'h05;
   localparam logic [7:0] CMD_RDPROT = 8'h3C;

   localparam int SECTOR_COUNT    = 8;
   localparam int SECTOR_IDX_W    = 3;
   localparam int SECTOR_ADDR_LSB = 16;

   localparam int LOCK_BIT   = 7;
   localparam int GLOB_HI    = 5;
   localparam int GLOB_LO    = 2;
   localparam int ST_WP_BIT  = 4;
   localparam int ST_SUM_LO  = 2;
   localparam int ST_WEL_BIT = 1;

   localparam logic [3:0] GLOB_ALL_ONE  = 4'hF;
   localparam logic [3:0] GLOB_ALL_ZERO = 4'h0;

   localparam logic [1:0] SUM_NONE = 2'h0;
   localparam logic [1:0] SUM_SOME = 2'h1;
   localparam logic [1:0] SUM_ALL  = 2'h3;

   localparam logic       LOCK_RST   = 1'h0;
   localparam logic       WEL_RST    = 1'h0;
   localparam logic [7:0] SECTOR_RST = 8'hFF;
   localparam logic [3:0] SYNC_RST   = 4'h9;

   localparam logic [5:0] OPCODE_LAST = 6'h07;
   localparam logic [5:0] WDATA_LAST  = 6'h0F;
   localparam logic [5:0] ADDR_LAST   = 6'h1F;

   typedef enum logic [2:0] {
      S_CMD   = 3'h0,
      S_ADDR  = 3'h1,
      S_OUT   = 3'h3,
      S_WDATA = 3'h2,
      S_SKIP  = 3'h6
   } frame_state_t;

endpackage

// file: shared/pin_sync_if.sv
// Synchronised serial pins passed from the sampler to the frame logic
`timescale 1ns/1ps
interface pin_sync_if;
   logic cs_n;
   logic cs_rise;
   logic sck_rise;
   logic sck_fall;
   logic si;
   logic wp_n;
   modport drive (output cs_n, cs_rise, sck_rise, sck_fall, si, wp_n);
   modport take  (input  cs_n, cs_rise, sck_rise, sck_fall, si, wp_n);
endinterface

// file: logic/pin_sampler.sv
// Two-flop sampling of the serial pins and edge finding
`timescale 1ns/1ps
module pin_sampler
   import prot_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  srst,
   input  wire logic  raw_cs_n,
   input  wire logic  raw_sck,
   input  wire logic  raw_si,
   input  wire logic  raw_wp_n,
   pin_sync_if.drive  sp
);
   import prot_pkg::*;

   // Bit order: wp_n, si, sck, cs_n
   logic [3:0] meta_ff;
   logic [3:0] sync_ff;
   logic [1:0] last_ff;
   logic [3:0] nxt_meta;
   logic [3:0] nxt_sync;
   logic [1:0] nxt_last;

   always_comb begin
      nxt_meta = {raw_wp_n, raw_si, raw_sck, raw_cs_n};
      nxt_sync = meta_ff;
      nxt_last = sync_ff[1:0];
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         meta_ff <= SYNC_RST;
         sync_ff <= SYNC_RST;
         last_ff <= SYNC_RST[1:0];
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
         last_ff <= nxt_last;
      end
   end

   assign sp.cs_n     = sync_ff[0];
   assign sp.cs_rise  = sync_ff[0] & ~last_ff[0];
   assign sp.sck_rise = sync_ff[1] & ~last_ff[1];
   assign sp.sck_fall = ~sync_ff[1] & last_ff[1];
   assign sp.si       = sync_ff[2];
   assign sp.wp_n     = sync_ff[3];
endmodule // pin_sampler

// file: logic/sector_bank.sv
// Per-sector protection bits with global set and clear and a summary
`timescale 1ns/1ps
module sector_bank
   import prot_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    srst,
   input  wire logic                    glob_set,
   input  wire logic                    glob_clr,
   output logic [SECTOR_COUNT-1:0]      bits,
   output logic [1:0]                   summary
);
   import prot_pkg::*;

   logic [SECTOR_COUNT-1:0] bits_ff;
   logic [SECTOR_COUNT-1:0] nxt_bits;
   logic [1:0]              summary_ff;
   logic [1:0]              nxt_summary;

   always_comb begin
      nxt_bits = bits_ff;
      if (glob_set) begin
         nxt_bits = {SECTOR_COUNT{1'b1}};
      end else if (glob_clr) begin
         nxt_bits = {SECTOR_COUNT{1'b0}};
      end
      if (&nxt_bits) begin
         nxt_summary = SUM_ALL;
      end else if (|nxt_bits) begin
         nxt_summary = SUM_SOME;
      end else begin
         nxt_summary = SUM_NONE;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         bits_ff    <= SECTOR_RST;
         summary_ff <= SUM_ALL;
      end else begin
         bits_ff    <= nxt_bits;
         summary_ff <= nxt_summary;
      end
   end

   assign bits    = bits_ff;
   assign summary = summary_ff;
endmodule // sector_bank

// file: logic/flash_sector_protection_global_ctl.sv
// Serial frame decoder for global protection, lock handling and readback
`timescale 1ns/1ps
module flash_sector_protection_global_ctl
   import prot_pkg::*;
(
   input  wire logic                     CORE_CLK,
   input  wire logic                     SRST,
   input  wire logic                     CS_N,
   input  wire logic                     SCK,
   input  wire logic                     SI,
   input  wire logic                     WP_N,
   output logic                          SO_O,
   output logic                          SO_OE_N,
   output logic                          PROTECTION_REGS_LOCK,
   output logic                          WRITE_ENABLE_LATCH,
   output logic [1:0]                    SOFTWARE_PROTECT_SUMMARY,
   output logic [7:0]                    STATUS_BYTE,
   output logic [prot_pkg::SECTOR_COUNT-1:0] SECTOR_PROT
);
   import prot_pkg::*;

   pin_sync_if sp ();

   pin_sampler u_sampler (
      .clk      (CORE_CLK),
      .srst     (SRST),
      .raw_cs_n (CS_N),
      .raw_sck  (SCK),
      .raw_si   (SI),
      .raw_wp_n (WP_N),
      .sp       (sp.drive)
   );

   // Frame tracking
   frame_state_t state_ff;
   frame_state_t nxt_state;
   logic [5:0]   bitcnt_ff;
   logic [5:0]   nxt_bitcnt;
   logic [7:0]   shift_ff;
   logic [7:0]   nxt_shift;
   logic [7:0]   opcode_ff;
   logic [7:0]   nxt_opcode;
   logic         op_valid_ff;
   logic         nxt_op_valid;
   logic [23:0]  addr_ff;
   logic [23:0]  nxt_addr;
   logic [7:0]   wdata_ff;
   logic [7:0]   nxt_wdata;
   logic         wdata_ok_ff;
   logic         nxt_wdata_ok;

   // Output path
   logic         so_ff;
   logic         nxt_so;
   logic         so_oe_n_ff;
   logic         nxt_so_oe_n;
   logic [7:0]   stat_sh_ff;
   logic [7:0]   nxt_stat_sh;

   // Protection state
   logic         lock_ff;
   logic         nxt_lock;
   logic         wel_ff;
   logic         nxt_wel;
   logic [7:0]   status_ff;
   logic [7:0]   nxt_status;
   logic         glob_set;
   logic         glob_clr;

   logic [SECTOR_COUNT-1:0] sector_bits;
   logic [1:0]              summary;

   sector_bank u_bank (
      .clk      (CORE_CLK),
      .srst     (SRST),
      .glob_set (glob_set),
      .glob_clr (glob_clr),
      .bits     (sector_bits),
      .summary  (summary)
   );

   logic [7:0]              shift_in;
   logic                    on_byte;
   logic                    hw_locked;
   logic [3:0]              glob_field;
   logic [SECTOR_IDX_W-1:0] sector_idx;
   logic                    sector_bit;
   logic                    wrsr_commit;

   always_comb begin
      shift_in   = {shift_ff[6:0], sp.si};
      on_byte    = (bitcnt_ff[2:0] == 3'h0);
      hw_locked  = ~sp.wp_n & lock_ff;
      glob_field = wdata_ff[GLOB_HI:GLOB_LO];
      sector_idx = addr_ff[SECTOR_ADDR_LSB +: SECTOR_IDX_W];
      sector_bit = sector_bits[sector_idx];
      // A status write counts only with whole bytes and the latch set
      wrsr_commit = sp.cs_rise & op_valid_ff & (opcode_ff == CMD_WRSR)
                    & wdata_ok_ff & on_byte & wel_ff;
   end

   // Frame decoding on sampled clock edges
   always_comb begin
      nxt_state    = state_ff;
      nxt_bitcnt   = bitcnt_ff;
      nxt_shift    = shift_ff;
      nxt_opcode   = opcode_ff;
      nxt_op_valid = op_valid_ff;
      nxt_addr     = addr_ff;
      nxt_wdata    = wdata_ff;
      nxt_wdata_ok = wdata_ok_ff;
      nxt_so       = so_ff;
      nxt_so_oe_n  = so_oe_n_ff;
      nxt_stat_sh  = stat_sh_ff;
      if (sp.cs_n) begin
         // Idle between frames; output released at once
         nxt_state    = S_CMD;
         nxt_bitcnt   = 6'h00;
         nxt_so_oe_n  = 1'b1;
         nxt_so       = 1'b0;
         if (!sp.cs_rise) begin
            nxt_op_valid = 1'b0;
            nxt_wdata_ok = 1'b0;
         end
      end else if (sp.sck_rise) begin
         nxt_shift  = shift_in;
         nxt_bitcnt = bitcnt_ff + 6'h01;
         case (state_ff)
            S_CMD: begin
               if (bitcnt_ff == OPCODE_LAST) begin
                  nxt_opcode   = shift_in;
                  nxt_op_valid = 1'b1;
                  if (shift_in == CMD_RDPROT) begin
                     nxt_state = S_ADDR;
                  end else if (shift_in == CMD_WRSR) begin
                     nxt_state = S_WDATA;
                  end else if (shift_in == CMD_RDSR) begin
                     nxt_state   = S_OUT;
                     nxt_stat_sh = status_ff;
                  end else begin
                     nxt_state = S_SKIP;
                  end
               end
            end
            S_ADDR: begin
               nxt_addr = {addr_ff[22:0], sp.si};
               if (bitcnt_ff == ADDR_LAST) begin
                  nxt_state = S_OUT;
               end
            end
            S_WDATA: begin
               if (bitcnt_ff == WDATA_LAST) begin
                  nxt_wdata    = shift_in;
                  nxt_wdata_ok = 1'b1;
                  nxt_state    = S_SKIP;
               end
            end
            S_OUT: begin
               // Incoming bits are ignored while replying
            end
            S_SKIP: begin
               // Trailing bits are ignored
            end
            default: begin
               nxt_state = S_SKIP;
            end
         endcase
      end else if (sp.sck_fall && state_ff == S_OUT) begin
         nxt_so_oe_n = 1'b0;
         if (opcode_ff == CMD_RDPROT) begin
            // Every bit of the repeated byte equals the sector bit
            nxt_so = sector_bit;
         end else begin
            nxt_so      = stat_sh_ff[7];
            nxt_stat_sh = {stat_sh_ff[6:0], stat_sh_ff[7]};
         end
      end
   end

   // Latch, lock and global decisions at chip select release
   always_comb begin
      nxt_wel  = wel_ff;
      nxt_lock = lock_ff;
      glob_set = 1'b0;
      glob_clr = 1'b0;
      if (sp.cs_rise && op_valid_ff && on_byte) begin
         if (opcode_ff == CMD_WREN) begin
            nxt_wel = 1'b1;
         end else if (opcode_ff == CMD_WRDI) begin
            nxt_wel = 1'b0;
         end
      end
      if (sp.cs_rise && op_valid_ff && opcode_ff == CMD_WRSR) begin
         nxt_wel = 1'b0;
      end
      if (wrsr_commit) begin
         if (hw_locked) begin
            nxt_lock = lock_ff;
         end else if (lock_ff) begin
            // Soft lock: only the lock loads, sectors untouched
            nxt_lock = wdata_ff[LOCK_BIT];
         end else begin
            nxt_lock = wdata_ff[LOCK_BIT];
            if (glob_field == GLOB_ALL_ONE) begin
               glob_set = 1'b1;
            end else if (glob_field == GLOB_ALL_ZERO) begin
               glob_clr = 1'b1;
            end
            // Mixed patterns leave the sector bits alone
         end
      end
   end

   // Status image: lock, pin level, summary, latch
   always_comb begin
      nxt_status                            = 8'h00;
      nxt_status[LOCK_BIT]                  = lock_ff;
      nxt_status[ST_WP_BIT]                 = sp.wp_n;
      nxt_status[ST_SUM_LO +: 2]            = summary;
      nxt_status[ST_WEL_BIT]                = wel_ff;
   end

   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         state_ff    <= S_CMD;
         bitcnt_ff   <= 6'h00;
         shift_ff    <= 8'h00;
         opcode_ff   <= 8'h00;
         op_valid_ff <= 1'b0;
         addr_ff     <= 24'h000000;
         wdata_ff    <= 8'h00;
         wdata_ok_ff <= 1'b0;
         so_ff       <= 1'b0;
         so_oe_n_ff  <= 1'b1;
         stat_sh_ff  <= 8'h00;
         lock_ff     <= LOCK_RST;
         wel_ff      <= WEL_RST;
         status_ff   <= 8'h00;
      end else begin
         state_ff    <= nxt_state;
         bitcnt_ff   <= nxt_bitcnt;
         shift_ff    <= nxt_shift;
         opcode_ff   <= nxt_opcode;
         op_valid_ff <= nxt_op_valid;
         addr_ff     <= nxt_addr;
         wdata_ff    <= nxt_wdata;
         wdata_ok_ff <= nxt_wdata_ok;
         so_ff       <= nxt_so;
         so_oe_n_ff  <= nxt_so_oe_n;
         stat_sh_ff  <= nxt_stat_sh;
         lock_ff     <= nxt_lock;
         wel_ff      <= nxt_wel;
         status_ff   <= nxt_status;
      end
   end

   assign SO_O                     = so_ff;
   assign SO_OE_N                  = so_oe_n_ff;
   assign PROTECTION_REGS_LOCK     = lock_ff;
   assign WRITE_ENABLE_LATCH       = wel_ff;
   assign SOFTWARE_PROTECT_SUMMARY = summary;
   assign STATUS_BYTE              = status_ff;
   assign SECTOR_PROT              = sector_bits;
endmodule // flash_sector_protection_global_ctl

// file: tb/flash_sector_protection_global_ctl_monitor.sv
// Port checker for the sector protection block
`timescale 1ns/1ps
module flash_sector_protection_global_ctl_monitor
   import prot_pkg::*;
(
   input wire logic                          CORE_CLK,
   input wire logic                          SRST,
   input wire logic                          CS_N,
   input wire logic                          SCK,
   input wire logic                          SI,
   input wire logic                          WP_N,
   input wire logic                          SO_O,
   input wire logic                          SO_OE_N,
   input wire logic                          PROTECTION_REGS_LOCK,
   input wire logic                          WRITE_ENABLE_LATCH,
   input wire logic [1:0]                    SOFTWARE_PROTECT_SUMMARY,
   input wire logic [7:0]                    STATUS_BYTE,
   input wire logic [prot_pkg::SECTOR_COUNT-1:0] SECTOR_PROT
);
   import prot_pkg::*;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SRST);
   reset_values_a: assert property (
      $fell(SRST) |-> SECTOR_PROT == SECTOR_RST && !PROTECTION_REGS_LOCK && SO_OE_N)
      else $error("sector bits not all set after reset");
   summary_track_a: assert property (
      SOFTWARE_PROTECT_SUMMARY == (SECTOR_PROT == 8'hFF ? SUM_ALL :
            (SECTOR_PROT == 8'h00 ? SUM_NONE : SUM_SOME)))
      else $error("summary does not match sector bits");
   locked_sectors_a: assert property (
      PROTECTION_REGS_LOCK |=> $stable(SECTOR_PROT))
      else $error("sector bits changed while locked");
   hard_lock_hold_a: assert property (
      !WP_N [*4] ##0 PROTECTION_REGS_LOCK |=> PROTECTION_REGS_LOCK)
      else $error("lock cleared under hardware lock");
   glob_values_a: assert property (
      $changed(SECTOR_PROT) |-> SECTOR_PROT inside {8'hFF, 8'h00})
      else $error("sector bits changed to a mixed value");
   latch_needed_a: assert property (
      $changed(SECTOR_PROT) |-> $past(WRITE_ENABLE_LATCH) && !WRITE_ENABLE_LATCH)
      else $error("sector bits changed without write enable");
   commit_at_end_a: assert property (
      $changed(PROTECTION_REGS_LOCK) || $changed(SECTOR_PROT) |-> $past(CS_N, 2))
      else $error("status write applied before chip select release");
   release_so_a: assert property (
      CS_N [*4] |=> SO_OE_N)
      else $error("serial output still driven after deselect");
   reply_on_fall_a: assert property (
      $changed(SO_O) && !SO_OE_N |-> !$past(SCK, 2))
      else $error("serial output moved away from a falling clock");
   status_image_a: assert property (
      1 |=> STATUS_BYTE[7:5] == {$past(PROTECTION_REGS_LOCK), 2'h0} && STATUS_BYTE[3:0] ==
            {$past(SOFTWARE_PROTECT_SUMMARY), $past(WRITE_ENABLE_LATCH), 1'b0})
      else $error("status byte image wrong");
endmodule // flash_sector_protection_global_ctl_monitor

bind flash_sector_protection_global_ctl flash_sector_protection_global_ctl_monitor i_mon (
   .CORE_CLK(CORE_CLK), .SRST(SRST), .CS_N(CS_N), .SCK(SCK), .SI(SI), .WP_N(WP_N),
   .SO_O(SO_O), .SO_OE_N(SO_OE_N), .PROTECTION_REGS_LOCK(PROTECTION_REGS_LOCK),
   .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH), .SOFTWARE_PROTECT_SUMMARY(SOFTWARE_PROTECT_SUMMARY),
   .STATUS_BYTE(STATUS_BYTE), .SECTOR_PROT(SECTOR_PROT));

// file: tb/spi_host_model.sv
// Host serial controller model: mode 0 frames, MSB first
`timescale 1ns/1ps
module spi_host_model (
   output logic      cs_n,
   output logic      sck,
   output logic      si,
   input  wire logic so
);
   initial begin
      cs_n = 1'b1;
      sck  = 1'b0;
      si   = 1'b0;
   end
   // Sends n bits from tx[39] down; rx keeps the last 8 bits sampled
   task automatic xfer(input logic [39:0] tx, input int n, output logic [7:0] rx);
      rx   = 8'h00;
      cs_n = 1'b0;
      #100;
      for (int i = 0; i < n; i++) begin
         si = tx[39-i];
         #62.5 sck = 1'b1;
         rx = {rx[6:0], so};
         #62.5 sck = 1'b0;
      end
      #62.5 cs_n = 1'b1;
      si = ~si; // Released line shows no stale level
      #100;
   endtask
endmodule // spi_host_model

// file: tb/flash_sector_protection_global_ctl_tb_top.sv
// Sequence tests of global protection, locking and protection readback
`timescale 1ns/1ps
module flash_sector_protection_global_ctl_tb_top;
   import prot_pkg::*;
   logic       core_clk, srst, wp_n, so_o, so_oe_n, lock, latch, exp_lock;
   logic [1:0] summary;
   logic [7:0] status, sect, rx, exp_sect;
   int         num_errors, checks_done;
   wire logic  cs_n, sck, si;
   // Write data, then expected sector bits and lock after each step
   logic [7:0] wdat [10] = '{8'h00, 8'h7F, 8'h00, 8'h24, 8'hF0, 8'h7F, 8'h7F, 8'hFF, 8'h0F, 8'h00};
   logic [7:0] wsec [10] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00};
   logic [9:0] wlck = 10'h090;

   flash_sector_protection_global_ctl i_flash_sector_protection_global_ctl (
      .CORE_CLK(core_clk), .SRST(srst), .CS_N(cs_n), .SCK(sck), .SI(si), .WP_N(wp_n),
      .SO_O(so_o), .SO_OE_N(so_oe_n), .PROTECTION_REGS_LOCK(lock),
      .WRITE_ENABLE_LATCH(latch), .SOFTWARE_PROTECT_SUMMARY(summary),
      .STATUS_BYTE(status), .SECTOR_PROT(sect));
   spi_host_model i_spi_host_model (
      .cs_n(cs_n), .sck(sck), .si(si), .so(so_oe_n ? ~so_o : so_o));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   function automatic logic [1:0] sum_of(input logic [7:0] s);
      return (s == 8'hFF) ? SUM_ALL : ((s == 8'h00) ? SUM_NONE : SUM_SOME);
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wsr(input logic [7:0] d, input logic en);
      if (en) i_spi_host_model.xfer({CMD_WREN, 32'h0}, 8, rx);
      i_spi_host_model.xfer({CMD_WRSR, d, 24'h0}, 16, rx);
   endtask
   task automatic state_chk();
      chk(sect, exp_sect);
      chk({7'h0, lock}, {7'h0, exp_lock});
      chk({6'h0, summary}, {6'h0, sum_of(exp_sect)});
      chk(status, {exp_lock, 2'h0, wp_n, sum_of(exp_sect), 2'h0});
   endtask
   task automatic rdp(input logic [23:0] addr, input logic [7:0] exp);
      i_spi_host_model.xfer({CMD_RDPROT, addr, 8'h00}, 40, rx);
      chk(rx, exp);
      chk({7'h0, so_oe_n}, 8'h01);
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      #500000;
      num_errors++;
      report_and_stop();
   end

   initial begin
      num_errors = 0;
      checks_done = 0;
      srst = 1'b1;
      wp_n = 1'b1;
      repeat (12) @(posedge core_clk);
      #1 srst = 1'b0;
      repeat (4) @(posedge core_clk);
      exp_sect = SECTOR_RST;
      exp_lock = 1'b0;
      state_chk();
      for (int i = 0; i < 10; i++) begin
         wsr(wdat[i], 1'b1);
         exp_sect = wsec[i];
         exp_lock = wlck[i];
         state_chk();
      end
      i_spi_host_model.xfer({CMD_WREN, 32'h0}, 8, rx);
      chk({7'h0, latch}, 8'h01);
      i_spi_host_model.xfer({CMD_WRDI, 32'h0}, 8, rx);
      wsr(8'h7F, 1'b0);
      state_chk();
      i_spi_host_model.xfer({CMD_WREN, 32'h0}, 8, rx);
      i_spi_host_model.xfer({CMD_WRSR, 8'h7F, 24'h0}, 12, rx);
      state_chk();
      rdp(24'h000000, 8'h00);
      wsr(8'h7F, 1'b1);
      exp_sect = 8'hFF;
      rdp(24'h07FFFF, 8'hFF);
      wsr(8'hF0, 1'b1);
      exp_lock = 1'b1;
      @(posedge core_clk) #1 wp_n = 1'b0;
      wsr(8'h00, 1'b1);
      state_chk();
      wsr(8'h0F, 1'b1);
      state_chk();
      rdp(24'h030000, 8'hFF);
      @(posedge core_clk) #1 wp_n = 1'b1;
      wsr(8'h0F, 1'b1);
      exp_lock = 1'b0;
      state_chk();
      wsr(8'h00, 1'b1);
      exp_sect = 8'h00;
      state_chk();
      i_spi_host_model.xfer({CMD_RDSR, 32'h0}, 16, rx);
      chk(rx, 8'h10);
      i_spi_host_model.xfer({CMD_RDPROT, 32'h0}, 36, rx);
      chk({7'h0, so_oe_n}, 8'h01);
      @(posedge core_clk) #1 srst = 1'b1;
      repeat (12) @(posedge core_clk);
      #1 srst = 1'b0;
      repeat (4) @(posedge core_clk);
      exp_sect = SECTOR_RST;
      state_chk();
      report_and_stop();
   end
endmodule // flash_sector_protection_global_ctl_tb_top
